// ===== emc_ctrl.sv
// External static memory controller: NOR/PSRAM and NAND access logic
`timescale 1ns/1ps
module emc_ctrl
    import emc_pkg::*;
#(
    parameter int AW = 16,
    parameter int DW = 16,
    parameter logic [CNT_W-1:0] DATA_CYC = 5'h02
)
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic controller_enable,
    input wire logic continuous_clock_enable,
    input wire logic [DIV_W-1:0] clock_divide_factor,
    input wire logic [SETUP_W-1:0] nor_address_setup,
    input wire logic [SETUP_W-1:0] nand_address_setup,
    input wire logic nand_bank_enable,
    input wire logic sequencer_start,
    input wire logic ecc_compute_enable,
    input wire logic rise_irq_enable,
    input wire logic fall_irq_enable,
    input wire logic rise_flag_clear,
    input wire logic fall_flag_clear,
    input wire logic ready_busy_input,
    input wire logic req_valid,
    input wire logic req_nand,
    input wire logic req_sync,
    input wire logic req_write,
    input wire logic [AW-1:0] req_addr,
    input wire logic [DW-1:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic rsp_error,
    output logic [DW-1:0] rsp_rdata,
    input wire logic [DW-1:0] mem_rdata,
    output logic [AW-1:0] mem_addr,
    output logic [DW-1:0] mem_wdata,
    output logic mem_data_oe,
    output logic nor_chip_select_n,
    output logic nand_chip_select_n,
    output logic address_valid_n,
    output logic write_enable_n,
    output logic output_enable_n,
    output logic mem_clk,
    output logic rise_event_flag,
    output logic fall_event_flag,
    output logic nand_irq,
    output logic [DW-1:0] ecc_result,
    output logic sequencer_busy
);
    typedef struct packed {
        emc_state_t state;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] adv_len;
        logic [2:0] gap;
        logic last_nor;
        logic is_nand;
        logic is_sync;
        logic is_write;
        logic is_seq;
        logic [AW-1:0] addr;
        logic [AW-1:0] seq_addr;
        logic [DW-1:0] wdata;
        logic [DW-1:0] rdata;
        logic [DW-1:0] ecc;
        logic [DW-1:0] rd_s1;
        logic [DW-1:0] rd_s2;
        logic [DIV_W-1:0] div_lat;
        logic nor_cs_n;
        logic nand_cs_n;
        logic adv_n;
        logic we_n;
        logic oe_n;
        logic data_oe;
        logic ready;
        logic rsp_valid;
        logic rsp_error;
        logic rb_s1;
        logic rb_s2;
        logic rb_prev;
        logic rise_f;
        logic fall_f;
        logic irq;
        logic ecc_en_prev;
        logic seq_busy;
    } emc_ctrl_st_t;

    localparam emc_ctrl_st_t RESET_ST = '{
        state: ST_IDLE, gap: GAP_MAX, nor_cs_n: 1'b1, nand_cs_n: 1'b1,
        adv_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, default: '0};

    emc_ctrl_st_t q;
    emc_ctrl_st_t d;
    logic take;
    logic rise_det;
    logic fall_det;
    logic gap_ok;

    emc_clk_if cif ();

    // Clock runs free when continuous, else only during sync accesses
    assign cif.run = continuous_clock_enable
        | (q.is_sync & (q.state != ST_IDLE));
    assign cif.factor = clock_divide_factor;

    emc_clkgen u_clkgen (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .cif(cif)
    );

    assign take = req_valid & q.ready;
    // Ready/busy edges seen on the synchronised level
    assign rise_det = q.rb_s2 & ~q.rb_prev;
    assign fall_det = ~q.rb_s2 & q.rb_prev;
    // Idle gap only matters after a NOR/PSRAM access
    assign gap_ok = !q.last_nor
        || (q.gap >= (q.is_nand ? IDLE_NAND_CYC : IDLE_NOR_CYC));

    // Next-state logic
    always_comb
    begin
        d = q;
        d.rsp_valid = 1'b0;
        d.rsp_error = 1'b0;
        d.rb_s1 = ready_busy_input;
        d.rb_s2 = q.rb_s1;
        d.rb_prev = q.rb_s2;
        d.rd_s1 = mem_rdata;
        d.rd_s2 = q.rd_s1;
        d.ecc_en_prev = ecc_compute_enable;
        // Edge flags: a new edge wins over a clear in the same cycle
        if (rise_flag_clear)
            d.rise_f = 1'b0;
        if (rise_det)
            d.rise_f = 1'b1;
        if (fall_flag_clear)
            d.fall_f = 1'b0;
        if (fall_det)
            d.fall_f = 1'b1;
        d.irq = (q.rise_f & rise_irq_enable)
            | (q.fall_f & fall_irq_enable);
        if (q.gap != GAP_MAX)
            d.gap = 3'(q.gap + 3'h1);
        case (q.state)
            ST_IDLE:
            begin
                if (take)
                begin
                    d.is_nand = req_nand;
                    d.is_sync = req_sync & ~req_nand;
                    d.is_write = req_write;
                    d.is_seq = 1'b0;
                    d.addr = req_addr;
                    d.wdata = req_wdata;
                    if (req_nand && !nand_bank_enable)
                    begin
                        d.rsp_valid = 1'b1;
                        d.rsp_error = 1'b1;
                    end
                    else
                        d.state = ST_GAP;
                end
                else if (sequencer_start && controller_enable)
                begin
                    // Sequencer ignores the bank enable
                    d.is_nand = 1'b1;
                    d.is_sync = 1'b0;
                    d.is_write = 1'b0;
                    d.is_seq = 1'b1;
                    d.addr = q.seq_addr;
                    d.seq_addr = AW'(q.seq_addr + 1'b1);
                    d.state = ST_GAP;
                end
            end
            ST_GAP:
            begin
                if (gap_ok)
                begin
                    if (q.is_nand)
                        d.nand_cs_n = 1'b0;
                    else
                        d.nor_cs_n = 1'b0;
                    if (q.is_sync)
                    begin
                        d.adv_n = 1'b0;
                        d.div_lat = clock_divide_factor;
                        d.cnt = 5'({1'b0, clock_divide_factor} + CNT_ONE);
                        d.state = ST_ADV;
                    end
                    else
                    begin
                        d.cnt = 5'(q.is_nand ? nand_address_setup
                            : nor_address_setup);
                        d.state = ST_SETUP;
                    end
                end
            end
            ST_ADV:
            begin
                // Strobe low for factor+1 kernel periods
                if (q.cnt == CNT_ONE)
                begin
                    d.adv_n = 1'b1;
                    d.cnt = 5'({1'b0, q.div_lat} + CNT_ONE) >> 1;
                    if (d.cnt == 5'h00)
                        d.cnt = CNT_ONE;
                    d.state = ST_HOLD;
                end
                else
                    d.cnt = 5'(q.cnt - CNT_ONE);
            end
            ST_HOLD:
            begin
                // Address kept on the bus, strobe already high
                if (q.cnt == CNT_ONE)
                begin
                    d.state = ST_DATA;
                    d.cnt = DATA_CYC;
                    d.we_n = ~q.is_write;
                    d.oe_n = q.is_write;
                    d.data_oe = q.is_write;
                end
                else
                    d.cnt = 5'(q.cnt - CNT_ONE);
            end
            ST_SETUP:
            begin
                if (q.cnt == 5'h00)
                begin
                    d.state = ST_DATA;
                    d.cnt = DATA_CYC;
                    d.we_n = ~q.is_write;
                    d.oe_n = q.is_write;
                    d.data_oe = q.is_write;
                end
                else
                    d.cnt = 5'(q.cnt - CNT_ONE);
            end
            ST_DATA:
            begin
                if (q.cnt <= CNT_ONE)
                begin
                    d.nor_cs_n = 1'b1;
                    d.nand_cs_n = 1'b1;
                    d.we_n = 1'b1;
                    d.oe_n = 1'b1;
                    d.data_oe = 1'b0;
                    d.rdata = q.rd_s2;
                    d.rsp_valid = ~q.is_seq;
                    d.last_nor = ~q.is_nand;
                    d.gap = 3'h1;
                    if (q.is_nand && ecc_compute_enable)
                        d.ecc = q.ecc ^ (q.is_write ? q.wdata : q.rd_s2);
                    d.state = ST_IDLE;
                end
                else
                    d.cnt = 5'(q.cnt - CNT_ONE);
            end
            default:
                d = RESET_ST;
        endcase
        // Rising ECC enable starts a fresh sector
        if (ecc_compute_enable && !q.ecc_en_prev)
            d.ecc = '0;
        d.ready = (d.state == ST_IDLE) & controller_enable;
        // Busy flag registered so the pin comes from a flop
        d.seq_busy = d.is_seq & (d.state != ST_IDLE);
        d.adv_len = d.adv_n ? 5'h00 : 5'(q.adv_len + CNT_ONE);
    end

    // State register; reset parks selects high and ready/busy low
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            q <= RESET_ST;
        else
            q <= d;
    end

    // Outputs straight from state
    assign req_ready = q.ready;
    assign rsp_valid = q.rsp_valid;
    assign rsp_error = q.rsp_error;
    assign rsp_rdata = q.rdata;
    assign mem_addr = q.addr;
    assign mem_wdata = q.wdata;
    assign mem_data_oe = q.data_oe;
    assign nor_chip_select_n = q.nor_cs_n;
    assign nand_chip_select_n = q.nand_cs_n;
    assign address_valid_n = q.adv_n;
    assign write_enable_n = q.we_n;
    assign output_enable_n = q.oe_n;
    assign mem_clk = cif.mem_clk;
    assign rise_event_flag = q.rise_f;
    assign fall_event_flag = q.fall_f;
    assign nand_irq = q.irq;
    assign ecc_result = q.ecc;
    assign sequencer_busy = q.seq_busy;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    nor_idle_gap_a: assert property (
        $rose(nor_chip_select_n) |-> nor_chip_select_n [*2])
        else $error("NOR select low again too soon");
    nand_after_nor_a: assert property (
        $fell(nand_chip_select_n) |-> $past(nor_chip_select_n)
            && $past(nor_chip_select_n, 2))
        else $error("NAND select too close to NOR select");
    adv_pulse_len_a: assert property (
        $rose(address_valid_n) |->
            $past(q.adv_len) == 5'({1'b0, q.div_lat} + CNT_ONE))
        else $error("address strobe length wrong");
    addr_hold_a: assert property (
        (q.state == ST_HOLD) |-> $stable(mem_addr) && address_valid_n
            && !nor_chip_select_n)
        else $error("address not held after strobe");
    bank_error_a: assert property (
        take && req_nand && !nand_bank_enable |=>
            rsp_valid && rsp_error && nand_chip_select_n)
        else $error("disabled bank request not refused");
    stale_flag_irq_a: assert property (
        (rise_event_flag && rise_irq_enable)
            || (fall_event_flag && fall_irq_enable) |=> nand_irq)
        else $error("interrupt missing for enabled flag");
    irq_cause_a: assert property (
        nand_irq |-> $past(rise_event_flag && rise_irq_enable)
            || $past(fall_event_flag && fall_irq_enable))
        else $error("interrupt without enabled flag");
    reset_rise_a: assert property (
        $rose(reset_n) ##0 ready_busy_input [*3] |-> ##[0:3] rise_event_flag)
        else $error("rising flag not set after reset");
    set_wins_a: assert property (
        rise_det |=> rise_event_flag)
        else $error("rising edge lost");
    ecc_restart_a: assert property (
        $rose(ecc_compute_enable) |=> ecc_result == '0)
        else $error("ECC not restarted");

    sync_access_c: cover property ($rose(address_valid_n));
    bank_error_c: cover property (rsp_valid && rsp_error);
    seq_bank_off_c: cover property (
        sequencer_busy && !nand_bank_enable && !nand_chip_select_n);
endmodule

// ===== emc_pkg.sv
// Shared constants and types of the external memory controller
package emc_pkg;
    // Idle kernel-clock periods after a NOR/PSRAM chip select rises
    localparam logic [2:0] IDLE_NOR_CYC = 3'h2;
    localparam logic [2:0] IDLE_NAND_CYC = 3'h1;
    localparam logic [2:0] GAP_MAX = 3'h7;
    localparam int DIV_W = 4;
    localparam int SETUP_W = 4;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
    localparam logic [CNT_W-1:0] CNT_TWO = 5'h02;
    // Access sequencing states
    typedef enum logic [2:0] {
        ST_IDLE, ST_GAP, ST_ADV, ST_HOLD, ST_SETUP, ST_DATA
    } emc_state_t;
endpackage

// ===== emc_clk_if.sv
// Link between access logic and output clock generator
`timescale 1ns/1ps
interface emc_clk_if;
    import emc_pkg::*;
    logic run;
    logic [DIV_W-1:0] factor;
    logic mem_clk;
    modport ctrl (output run, output factor, input mem_clk);
    modport gen (input run, input factor, output mem_clk);
endinterface

// ===== emc_clkgen.sv
// Output memory clock divider running on the kernel clock
`timescale 1ns/1ps
module emc_clkgen
    import emc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    emc_clk_if.gen cif
);
    typedef struct packed {
        logic clk;
        logic [CNT_W-1:0] cnt;
        logic [DIV_W-1:0] fac;
    } emc_gen_st_t;

    emc_gen_st_t q;
    emc_gen_st_t d;

    // Phase length: low phase rounds up, high phase rounds down, min one
    function automatic logic [CNT_W-1:0] phase_len(
        input logic [DIV_W-1:0] f, input logic hi);
        logic [CNT_W-1:0] len;
        len = 5'h00;
        if (hi)
            len = 5'({1'b0, f} + CNT_ONE) >> 1;
        else
            len = 5'({1'b0, f} + CNT_TWO) >> 1;
        if (len == 5'h00)
            len = CNT_ONE;
        return len;
    endfunction

    // Factor is re-latched at every phase edge, so one period may mix two factors
    always_comb
    begin
        d = q;
        if (!cif.run)
        begin
            d.clk = 1'b0;
            d.cnt = 5'h00;
            d.fac = cif.factor;
        end
        else if (q.cnt == 5'(phase_len(q.fac, q.clk) - CNT_ONE))
        begin
            d.clk = ~q.clk;
            d.cnt = 5'h00;
            d.fac = cif.factor;
        end
        else
            d.cnt = 5'(q.cnt + CNT_ONE);
    end

    // State register
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            q <= '0;
        else
            q <= d;
    end

    assign cif.mem_clk = q.clk;

    stopped_low_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !cif.run |=> !cif.mem_clk)
        else $error("memory clock not parked low when stopped");
endmodule

// ===== emc_mem_model.sv
// Behavioural NOR/PSRAM and NAND memory answering controller reads
`timescale 1ns/1ps
module emc_mem_model
(
    input wire logic ref_clk,
    input wire logic nor_chip_select_n,
    input wire logic nand_chip_select_n,
    input wire logic output_enable_n,
    input wire logic write_enable_n,
    input wire logic mem_data_oe,
    input wire logic [15:0] mem_wdata,
    input wire logic [15:0] mem_addr,
    output logic [15:0] mem_rdata,
    output logic [15:0] wr_seen
);
    logic [15:0] hold_q = 16'h0000;
    logic drive;
    // Drive only while a device is selected and output enable is low
    assign drive = !output_enable_n && !(nor_chip_select_n && nand_chip_select_n);
    // Released bus shows the inverse of the last word, never a stale copy
    assign mem_rdata = drive ? (mem_addr ^ 16'h5a3c) : ~hold_q;
    // Remember the last driven word
    always @(posedge ref_clk)
    begin
        if (drive)
            hold_q <= mem_addr ^ 16'h5a3c;
    end
    // Last word written while selected, strobed and driven
    always @(posedge ref_clk)
    begin
        if (!write_enable_n && mem_data_oe
            && !(nor_chip_select_n && nand_chip_select_n))
            wr_seen <= mem_wdata;
    end
endmodule

// ===== test_external_memory_controller.sv
// Self-checking testbench of the external memory controller
`timescale 1ns/1ps
module test_external_memory_controller;
    import emc_pkg::*;
    logic ref_clk, reset_n, controller_enable, continuous_clock_enable;
    logic [3:0] clock_divide_factor, nor_address_setup, nand_address_setup;
    logic nand_bank_enable, sequencer_start, ecc_compute_enable;
    logic rise_irq_enable, fall_irq_enable, rise_flag_clear, fall_flag_clear;
    logic ready_busy_input, req_valid, req_nand, req_sync, req_write;
    logic [15:0] req_addr, req_wdata, mem_rdata, mem_addr, mem_wdata;
    logic [15:0] rsp_rdata, ecc_result, r_data, wr_seen;
    logic req_ready, rsp_valid, rsp_error, mem_data_oe, nor_chip_select_n;
    logic nand_chip_select_n, address_valid_n, write_enable_n;
    logic output_enable_n, mem_clk, rise_event_flag, fall_event_flag;
    logic nand_irq, sequencer_busy, r_err, prev_nor, prev_nand, prev_adv;
    int n_fail = 0;
    int compares = 0;
    int cyc = 0;
    int gap_cnt = 0;
    int nor_gap, nand_gap, adv_cnt, adv_len;

    emc_ctrl #(.AW(16), .DW(16), .DATA_CYC(5'h04)) dut_u (.*);
    emc_mem_model mem_u (.ref_clk(ref_clk),
        .nor_chip_select_n(nor_chip_select_n),
        .nand_chip_select_n(nand_chip_select_n),
        .output_enable_n(output_enable_n), .mem_addr(mem_addr),
        .write_enable_n(write_enable_n), .mem_data_oe(mem_data_oe),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .wr_seen(wr_seen));

    // Kernel clock, 40 ns period
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // Select gaps and address strobe length seen on the pins
    always @(negedge ref_clk)
    begin
        if (!prev_nor && nor_chip_select_n)
            gap_cnt = 1;
        else if (nor_chip_select_n && nand_chip_select_n)
            gap_cnt++;
        if (prev_nor && !nor_chip_select_n)
            nor_gap = gap_cnt;
        if (prev_nand && !nand_chip_select_n)
            nand_gap = gap_cnt;
        if (!address_valid_n)
            adv_cnt++;
        else if (!prev_adv)
            adv_len = adv_cnt;
        if (address_valid_n)
            adv_cnt = 0;
        prev_nor = nor_chip_select_n;
        prev_nand = nand_chip_select_n;
        prev_adv = address_valid_n;
    end

    // Hang guard
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            wrap_up();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wait_for(ref logic s, input logic v, input int n);
        int i;
        for (i = 0; i < n && s !== v; i++)
            @(negedge ref_clk);
    endtask

    // One bus request held until taken, then wait for its answer
    task automatic bus(input logic nd, sy, wr, input logic [15:0] a, d);
        int i;
        req_valid = 1'b1;
        req_nand = nd;
        req_sync = sy;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        wait_for(req_ready, 1'b1, 50);
        @(negedge ref_clk);
        req_valid = 1'b0;
        for (i = 0; i < 80 && rsp_valid !== 1'b1; i++)
            @(negedge ref_clk);
        chk("rsp_valid", rsp_valid, 1'b1);
        r_err = rsp_error;
        r_data = rsp_rdata;
    endtask

    // Back-to-back NOR writes, then NOR to NAND read
    task automatic t_gaps;
        bus(1'b0, 1'b0, 1'b1, 16'h0010, 16'h1234);
        bus(1'b0, 1'b0, 1'b1, 16'h0011, 16'h4321);
        chk("nor_gap", nor_gap >= 2, 1);
        chk("wr_data", wr_seen, 16'h4321);
        bus(1'b1, 1'b0, 1'b0, 16'h0020, 16'h0000);
        chk("nand_gap", nand_gap >= 1, 1);
        chk("nand_err", r_err, 1'b0);
        chk("nand_data", r_data, 16'h0020 ^ 16'h5a3c);
    endtask

    // Synchronous NOR read: strobe low factor+1 cycles
    task automatic t_sync;
        bus(1'b0, 1'b1, 1'b0, 16'h0033, 16'h0000);
        chk("adv_len", adv_len, 32'(clock_divide_factor) + 1);
        chk("sync_data", r_data, 16'h0033 ^ 16'h5a3c);
    endtask

    // Bank off: bus error without select, sequencer still reaches NAND
    task automatic t_bank;
        nand_bank_enable = 1'b0;
        bus(1'b1, 1'b0, 1'b1, 16'h0040, 16'h00ff);
        chk("bank_err", r_err, 1'b1);
        chk("bank_cs", nand_chip_select_n, 1'b1);
        chk("bank_wr", wr_seen, 16'h4321);
        sequencer_start = 1'b1;
        wait_for(nand_chip_select_n, 1'b0, 60);
        chk("seq_cs", nand_chip_select_n, 1'b0);
        sequencer_start = 1'b0;
        wait_for(sequencer_busy, 1'b0, 60);
        chk("seq_idle", sequencer_busy, 1'b0);
        nand_bank_enable = 1'b1;
    endtask

    // Edge flags and interrupt gating
    task automatic t_irq;
        rise_irq_enable = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk("stale_irq", nand_irq, 1'b1);
        rise_flag_clear = 1'b1;
        @(negedge ref_clk);
        rise_flag_clear = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk("rise_clr", {rise_event_flag, nand_irq}, 2'h0);
        ready_busy_input = 1'b0;
        wait_for(fall_event_flag, 1'b1, 10);
        chk("fall_flag", fall_event_flag, 1'b1);
        fall_flag_clear = 1'b1;
        @(negedge ref_clk);
        fall_flag_clear = 1'b0;
        fall_irq_enable = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk("no_stale", nand_irq, 1'b0);
        ready_busy_input = 1'b1;
        {rise_irq_enable, fall_irq_enable} = 2'h0;
    endtask

    // ECC accumulates a read and restarts on each enable
    task automatic t_ecc;
        ecc_compute_enable = 1'b1;
        repeat (2) @(negedge ref_clk);
        bus(1'b1, 1'b0, 1'b0, 16'h0055, 16'h0000);
        chk("ecc_val", ecc_result, 16'h0055 ^ 16'h5a3c);
        ecc_compute_enable = 1'b0;
        repeat (2) @(negedge ref_clk);
        ecc_compute_enable = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk("ecc_restart", ecc_result, 16'h0000);
        ecc_compute_enable = 1'b0;
    endtask

    // Factor change in the safe order; clock stands low when stopped
    task automatic t_clk;
        int i, edges, last_rise, period;
        logic pc;
        controller_enable = 1'b0;
        @(negedge ref_clk);
        continuous_clock_enable = 1'b0;
        repeat (10) @(negedge ref_clk);
        chk("clk_stop", mem_clk, 1'b0);
        clock_divide_factor = 4'h3;
        @(negedge ref_clk);
        continuous_clock_enable = 1'b1;
        @(negedge ref_clk);
        controller_enable = 1'b1;
        edges = 0;
        last_rise = -1;
        period = 0;
        pc = mem_clk;
        for (i = 0; i < 24; i++)
        begin
            @(negedge ref_clk);
            if (mem_clk === 1'b1 && pc === 1'b0)
            begin
                edges++;
                if (last_rise >= 0)
                    period = i - last_rise;
                last_rise = i;
            end
            pc = mem_clk;
        end
        chk("clk_runs", edges > 0, 1);
        chk("clk_period", period, 32'(clock_divide_factor) + 1);
        bus(1'b0, 1'b1, 1'b0, 16'h0066, 16'h0000);
        chk("adv_len4", adv_len, 4);
    endtask

    task automatic wrap_up;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        {reset_n, sequencer_start, ecc_compute_enable, req_valid} = 4'h0;
        {rise_irq_enable, fall_irq_enable} = 2'h0;
        {rise_flag_clear, fall_flag_clear, req_nand, req_sync} = 4'h0;
        {req_write, req_addr, req_wdata} = 33'h0;
        {prev_nor, prev_nand, prev_adv} = 3'h7;
        {nor_gap, nand_gap, adv_cnt, adv_len} = {4{32'h0}};
        controller_enable = 1'b1;
        continuous_clock_enable = 1'b1;
        nand_bank_enable = 1'b1;
        clock_divide_factor = 4'h2;
        nor_address_setup = 4'h1;
        nand_address_setup = 4'h1;
        ready_busy_input = 1'b1;
        repeat (20) @(negedge ref_clk);
        chk("rst_cs", {nor_chip_select_n, nand_chip_select_n}, 2'h3);
        reset_n = 1'b1;
        wait_for(rise_event_flag, 1'b1, 8);
        chk("rst_rise", rise_event_flag, 1'b1);
        t_irq();
        t_gaps();
        t_sync();
        t_bank();
        t_ecc();
        t_clk();
        wrap_up();
    end
endmodule
